// >>> core/two_wire_slave_receiver.sv
// Two-wire slave receiver with slave transmit tail, register port and wake.
// Assumes open-drain pads outside, a 200 MHz CLOCK and same-domain ARB_LOST.
//
// Contract
// [RL1] Last byte acked by master: 0xC8, not addressed
// [RL2] Ack enabled: own and enabled general call recognised
// [RL3] Start request: issue START when bus free
// [RL4] Own address sits in upper seven bits
// [RL5] Address bit zero enables general call answer
// [RL6] Software enables with pattern 0100010x
// [RL7] Direction bit picks receive or transmit
// [RL8] Address plus write sets flag and status
// [RL9] Arbitration loss may lead into slave receive
// [RL10] Ack enable cleared: next byte gets NACK
// [RL11] Ack enable zero: address ignored, bus watched
// [RL12] Deep sleep: address match wakes the part
// [RL13] After wake, SCL held until flag cleared
// [RL14] Data register unreliable after sleep wake
// [RL15] Own address with write acked: 0x60
// [RL16] General call acked: 0x70
// [RL17] After arbitration loss: 0x68 or 0x78
// [RL18] Flag cleared: next byte acked per enable
// [RL19] Software masks prescaler bits in status
// [RL20] Bus released, status changes only with flag
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_receiver (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic [1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic ARB_LOST,
	input wire logic SLEEP_DEEP,
	output logic WAKE,
	output logic START_HELD
);
	line_if lines();

	tw_pkg::link_state_type state_reg;
	tw_pkg::link_state_type state_next;
	tw_pkg::link_state_type after_reg;
	tw_pkg::link_state_type after_next;
	logic flag_reg;
	logic ack_en_reg;
	logic start_req_reg;
	logic stop_req_reg;
	logic enable_reg;
	logic [7:0] status_reg;
	logic [1:0] prescale_reg;
	logic [7:0] data_reg;
	logic [7:0] own_addr_reg;
	logic [7:0] pend_reg;
	logic [7:0] pend_next;
	logic [7:0] rdata_reg;
	logic ack_drive_reg;
	logic ack_drive_next;
	logic gc_reg;
	logic gc_next;
	logic last_reg;
	logic last_next;
	logic master_ack_reg;
	logic lost_reg;
	logic wake_reg;
	logic [9:0] hold_count_reg;
	logic set_flag;
	logic [7:0] set_code;
	logic matched;
	logic shift_clear;
	logic shift_load;
	logic [7:0] shift_data;
	logic [3:0] shift_count;
	logic match_own;
	logic match_gc;
	logic ctrl_write;
	logic addr_done;

	// ****************************************************************
	// Line sampling and bit shifting
	// ****************************************************************
	line_sampler sampler (
		.clock(CLOCK),
		.rstn(RSTN),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.lines(lines)
	);

	byte_shifter #(.WIDTH(8)) shifter (
		.clock(CLOCK),
		.rstn(RSTN),
		.clear(shift_clear),
		.load(shift_load),
		.load_data(data_reg),
		.sample(lines.scl_rise && (state_reg == tw_pkg::S_ADDR || state_reg == tw_pkg::S_RX)),
		.shift(lines.scl_fall && state_reg == tw_pkg::S_TX),
		.bit_in(lines.sda),
		.data(shift_data),
		.count(shift_count)
	);

	// Status of a received data byte
	function automatic logic [7:0] rx_code(input logic gc, input logic acked);
		if (gc) begin
			rx_code = acked ? tw_pkg::ST_RX_ACK_GC : tw_pkg::ST_RX_NACK_GC;
		end else begin
			rx_code = acked ? tw_pkg::ST_RX_ACK_OWN : tw_pkg::ST_RX_NACK_OWN;
		end
	endfunction

	assign match_own = shift_data[7:1] == own_addr_reg[7:1]; // [RL4]
	assign match_gc = shift_data[7:1] == tw_pkg::GENERAL_CALL && own_addr_reg[tw_pkg::GC_EN_BIT]
		&& !shift_data[0]; // [RL5]
	assign ctrl_write = REG_WR && REG_ADDR == tw_pkg::CTRL_IDX;
	assign addr_done = state_reg == tw_pkg::S_ADDR && enable_reg && !stop_req_reg
		&& lines.scl_fall && shift_count == 4'h8;

	// ****************************************************************
	// Link state machine
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		pend_next = pend_reg;
		ack_drive_next = ack_drive_reg;
		gc_next = gc_reg;
		last_next = last_reg;
		set_flag = 1'b0;
		set_code = status_reg;
		matched = 1'b0;
		shift_clear = 1'b0;
		shift_load = 1'b0;
		if (!enable_reg) begin
			state_next = tw_pkg::S_IDLE;
			ack_drive_next = 1'b0;
		end else if (state_reg == tw_pkg::S_START || state_reg == tw_pkg::S_HELD) begin
			if (state_reg == tw_pkg::S_START && hold_count_reg == tw_pkg::START_HOLD_LAST) begin
				state_next = tw_pkg::S_HELD;
			end else if (state_reg == tw_pkg::S_HELD && !start_req_reg) begin
				state_next = tw_pkg::S_IDLE;
			end
		end else if (lines.start_seen) begin
			// Address collection runs even with ack disabled
			state_next = tw_pkg::S_ADDR; // [RL11]
			shift_clear = 1'b1;
			ack_drive_next = 1'b0;
		end else if (lines.stop_seen || stop_req_reg) begin
			state_next = tw_pkg::S_IDLE;
			ack_drive_next = 1'b0;
		end else begin
			case (state_reg)
				tw_pkg::S_IDLE: begin
					if (start_req_reg && !lines.bus_busy) begin
						state_next = tw_pkg::S_START; // [RL3]
					end
				end
				tw_pkg::S_ADDR: begin
					if (addr_done) begin
						if ((match_own || match_gc) && ack_en_reg) begin // [RL2] [RL11] [RL12]
							state_next = tw_pkg::S_ACK_OUT;
							ack_drive_next = 1'b1;
							gc_next = match_gc;
							matched = 1'b1;
							if (shift_data[0]) begin
								after_next = tw_pkg::S_TX; // [RL7]
								pend_next = lost_reg ? tw_pkg::ST_ARB_OWN_R : tw_pkg::ST_OWN_R;
							end else if (match_gc) begin
								after_next = tw_pkg::S_RX; // [RL7] [RL9]
								pend_next = lost_reg ? tw_pkg::ST_ARB_GC_W : tw_pkg::ST_GC_W; // [RL16] [RL17]
							end else begin
								after_next = tw_pkg::S_RX;
								pend_next = lost_reg ? tw_pkg::ST_ARB_OWN_W : tw_pkg::ST_OWN_W; // [RL15] [RL17]
							end
						end else begin
							state_next = tw_pkg::S_IDLE;
						end
					end
				end
				tw_pkg::S_ACK_OUT: begin
					if (lines.scl_fall) begin
						ack_drive_next = 1'b0;
						set_flag = 1'b1; // [RL8]
						set_code = pend_reg;
						state_next = tw_pkg::S_WAIT_SW;
					end
				end
				tw_pkg::S_WAIT_SW: begin
					if (!flag_reg) begin
						if (after_reg == tw_pkg::S_TX) begin
							shift_load = 1'b1;
							last_next = !ack_en_reg;
							state_next = tw_pkg::S_TX;
						end else if (after_reg == tw_pkg::S_RX) begin
							shift_clear = 1'b1; // [RL18]
							state_next = tw_pkg::S_RX;
						end else begin
							state_next = tw_pkg::S_IDLE;
						end
					end
				end
				tw_pkg::S_RX: begin
					if (lines.scl_fall && shift_count == 4'h8) begin
						ack_drive_next = ack_en_reg; // [RL10] [RL18]
						pend_next = rx_code(gc_reg, ack_en_reg);
						after_next = ack_en_reg ? tw_pkg::S_RX : tw_pkg::S_IDLE;
						state_next = tw_pkg::S_ACK_OUT;
					end
				end
				tw_pkg::S_TX: begin
					if (lines.scl_fall && shift_count == 4'h7) begin
						state_next = tw_pkg::S_TX_ACK;
					end
				end
				tw_pkg::S_TX_ACK: begin
					if (lines.scl_fall) begin
						set_flag = 1'b1;
						state_next = tw_pkg::S_WAIT_SW;
						if (!master_ack_reg) begin
							set_code = tw_pkg::ST_TX_NACK;
							after_next = tw_pkg::S_IDLE;
						end else if (last_reg) begin
							set_code = tw_pkg::ST_TX_LAST_ACK; // [RL1]
							after_next = tw_pkg::S_IDLE;
						end else begin
							set_code = tw_pkg::ST_TX_ACK;
							after_next = tw_pkg::S_TX;
						end
					end
				end
				default: begin
					state_next = tw_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= tw_pkg::S_IDLE;
			after_reg <= tw_pkg::S_IDLE;
			pend_reg <= tw_pkg::STATUS_RESET;
			ack_drive_reg <= 1'b0;
			gc_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			pend_reg <= pend_next;
			ack_drive_reg <= ack_drive_next;
			gc_reg <= gc_next;
			last_reg <= last_next;
		end
	end

	// ****************************************************************
	// Bus side helpers: master ack, arbitration, wake, start hold
	// ****************************************************************
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			master_ack_reg <= 1'b0;
		end else if (state_reg == tw_pkg::S_TX_ACK && lines.scl_rise) begin
			master_ack_reg <= !lines.sda;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			lost_reg <= 1'b0;
		end else if (ARB_LOST) begin
			lost_reg <= 1'b1;
		end else if (matched) begin
			lost_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			wake_reg <= 1'b0;
		end else if (!SLEEP_DEEP) begin
			wake_reg <= 1'b0;
		end else if (matched) begin
			wake_reg <= 1'b1; // [RL12]
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			hold_count_reg <= 10'h000;
		end else if (state_reg == tw_pkg::S_START) begin
			hold_count_reg <= hold_count_reg + 10'h001;
		end else begin
			hold_count_reg <= 10'h000;
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			flag_reg <= 1'b0;
		end else begin
			// Hardware set wins over a clear in the same cycle
			flag_reg <= set_flag || (flag_reg && !(ctrl_write && REG_WDATA[tw_pkg::FLAG_BIT]));
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ack_en_reg <= 1'b0;
			start_req_reg <= 1'b0;
			stop_req_reg <= 1'b0;
			enable_reg <= 1'b0;
		end else if (ctrl_write) begin
			ack_en_reg <= REG_WDATA[tw_pkg::ACK_EN_BIT];
			start_req_reg <= REG_WDATA[tw_pkg::START_BIT];
			stop_req_reg <= REG_WDATA[tw_pkg::STOP_BIT];
			enable_reg <= REG_WDATA[tw_pkg::ENABLE_BIT];
		end else if (stop_req_reg) begin
			stop_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			status_reg <= tw_pkg::STATUS_RESET;
		end else if (set_flag) begin
			status_reg <= set_code; // [RL20]
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			prescale_reg <= 2'h0;
			own_addr_reg <= tw_pkg::OWN_ADDR_RESET;
		end else if (REG_WR && REG_ADDR == tw_pkg::STATUS_IDX) begin
			prescale_reg <= REG_WDATA[1:0];
		end else if (REG_WR && REG_ADDR == tw_pkg::OWN_ADDR_IDX) begin
			own_addr_reg <= REG_WDATA;
		end
	end

	// Received bytes are not stored while asleep
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			data_reg <= tw_pkg::DATA_RESET;
		end else if (REG_WR && REG_ADDR == tw_pkg::DATA_IDX) begin
			data_reg <= REG_WDATA;
		end else if (state_reg == tw_pkg::S_RX && lines.scl_fall && shift_count == 4'h8
			&& !SLEEP_DEEP) begin
			data_reg <= shift_data; // [RL14]
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_reg <= 8'h00;
		end else if (!REG_RD) begin
			rdata_reg <= 8'h00;
		end else if (REG_ADDR == tw_pkg::CTRL_IDX) begin
			rdata_reg <= {flag_reg, ack_en_reg, start_req_reg, stop_req_reg, 1'b0, enable_reg, 2'h0};
		end else if (REG_ADDR == tw_pkg::STATUS_IDX) begin
			rdata_reg <= {status_reg[7:3], 1'b0, prescale_reg}; // [RL19]
		end else if (REG_ADDR == tw_pkg::DATA_IDX) begin
			rdata_reg <= data_reg;
		end else begin
			rdata_reg <= own_addr_reg;
		end
	end

	// ****************************************************************
	// Outputs: open-drain, only ever pulled low
	// ****************************************************************
	assign REG_RDATA = rdata_reg;
	assign SDA_OUT = 1'b0;
	assign SCL_OUT = 1'b0;
	assign SDA_OE = (state_reg == tw_pkg::S_ACK_OUT && ack_drive_reg) // [RL20]
		|| (state_reg == tw_pkg::S_TX && !shift_data[7])
		|| state_reg == tw_pkg::S_START || state_reg == tw_pkg::S_HELD;
	assign SCL_OE = (state_reg == tw_pkg::S_WAIT_SW && flag_reg) // [RL13]
		|| state_reg == tw_pkg::S_HELD;
	assign WAKE = wake_reg;
	assign START_HELD = state_reg == tw_pkg::S_HELD;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	last_ack_status_a: assert property ( // [RL1]
		(state_reg == tw_pkg::S_TX_ACK && enable_reg && !stop_req_reg && lines.scl_fall
			&& last_reg && master_ack_reg)
		|=> (status_reg == tw_pkg::ST_TX_LAST_ACK && flag_reg && after_reg == tw_pkg::S_IDLE)
	) else $error("last byte ack did not give C8");

	own_write_ack_a: assert property ( // [RL15]
		(addr_done && match_own && !shift_data[0] && ack_en_reg && !lost_reg)
		|=> (SDA_OE && pend_reg == tw_pkg::ST_OWN_W)
	) else $error("own write address not acked with 60");

	gc_ignored_a: assert property ( // [RL5]
		(addr_done && shift_data == 8'h00 && !own_addr_reg[0] && own_addr_reg[7:1] != 7'h00)
		|=> (state_reg == tw_pkg::S_IDLE && !SDA_OE)
	) else $error("general call answered while disabled");

	no_ack_disabled_a: assert property ( // [RL11]
		(addr_done && !ack_en_reg) |=> !SDA_OE [*2]
	) else $error("address acked with ack enable low");

	rx_nack_a: assert property ( // [RL10]
		(state_reg == tw_pkg::S_RX && enable_reg && !stop_req_reg && !lines.start_seen
			&& lines.scl_fall && shift_count == 4'h8 && !ack_en_reg)
		|=> (state_reg == tw_pkg::S_ACK_OUT && !SDA_OE)
	) else $error("byte acked after ack enable cleared");

	flag_status_a: assert property ( // [RL8]
		(state_reg == tw_pkg::S_ACK_OUT && enable_reg && !stop_req_reg && lines.scl_fall)
		|=> (flag_reg && status_reg == $past(pend_reg))
	) else $error("flag or status missing after ack slot");

	arb_status_a: assert property ( // [RL17]
		(addr_done && ack_en_reg && lost_reg && match_gc) |=> pend_reg == tw_pkg::ST_ARB_GC_W
	) else $error("general call after arbitration loss not 78");

	status_stable_a: assert property ( // [RL20]
		!$rose(flag_reg) |-> $stable(status_reg)
	) else $error("status changed without flag");

	scl_hold_a: assert property ( // [RL13]
		(state_reg == tw_pkg::S_WAIT_SW && $past(state_reg) == tw_pkg::S_ACK_OUT && enable_reg)
		|-> (SCL_OE until !flag_reg)
	) else $error("SCL released before flag clear");

	start_issue_a: assert property ( // [RL3]
		(state_reg == tw_pkg::S_IDLE && enable_reg && start_req_reg && !lines.bus_busy
			&& !lines.start_seen && !lines.stop_seen && !stop_req_reg && !ctrl_write)
		|=> (SDA_OE && !SCL_OE) [*8]
	) else $error("START not driven on free bus");

	wake_match_a: assert property ( // [RL12]
		(addr_done && SLEEP_DEEP && ack_en_reg && (match_own || match_gc)) |=> ##1 WAKE
	) else $error("no wake on address match in sleep");
endmodule
`default_nettype wire

// >>> include/tw_pkg.sv
// Shared constants of the two-wire slave block: register map, control bits,
// status codes, reset values, timing and the link state enumeration.
// Assumes a 200 MHz system clock.
package tw_pkg;

	// ****************************************************************
	// Register indices on the register port
	// ****************************************************************
	localparam logic [1:0] CTRL_IDX = 2'h0;
	localparam logic [1:0] STATUS_IDX = 2'h1;
	localparam logic [1:0] DATA_IDX = 2'h2;
	localparam logic [1:0] OWN_ADDR_IDX = 2'h3;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int FLAG_BIT = 7;
	localparam int ACK_EN_BIT = 6;
	localparam int START_BIT = 5;
	localparam int STOP_BIT = 4;
	localparam int ENABLE_BIT = 2;
	localparam int GC_EN_BIT = 0;

	// ****************************************************************
	// Reset values and fixed addresses
	// ****************************************************************
	localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [7:0] STATUS_RESET = 8'hF8;
	localparam logic [6:0] GENERAL_CALL = 7'h00;

	// ****************************************************************
	// Status codes, prescaler bits excluded
	// ****************************************************************
	localparam logic [7:0] ST_OWN_W = 8'h60;
	localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
	localparam logic [7:0] ST_GC_W = 8'h70;
	localparam logic [7:0] ST_ARB_GC_W = 8'h78;
	localparam logic [7:0] ST_RX_ACK_OWN = 8'h80;
	localparam logic [7:0] ST_RX_NACK_OWN = 8'h88;
	localparam logic [7:0] ST_RX_ACK_GC = 8'h90;
	localparam logic [7:0] ST_RX_NACK_GC = 8'h98;
	localparam logic [7:0] ST_OWN_R = 8'hA8;
	localparam logic [7:0] ST_ARB_OWN_R = 8'hB0;
	localparam logic [7:0] ST_TX_ACK = 8'hB8;
	localparam logic [7:0] ST_TX_NACK = 8'hC0;
	localparam logic [7:0] ST_TX_LAST_ACK = 8'hC8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int START_HOLD_NS = 4000;
	localparam int START_HOLD_CYCLES = (START_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam logic [9:0] START_HOLD_LAST = 10'(START_HOLD_CYCLES - 1);

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_ADDR = 4'b0001,
		S_ACK_OUT = 4'b0010,
		S_WAIT_SW = 4'b0011,
		S_RX = 4'b0100,
		S_TX = 4'b0101,
		S_TX_ACK = 4'b0110,
		S_START = 4'b0111,
		S_HELD = 4'b1000
	} link_state_type;

endpackage

// >>> include/line_if.sv
// Synchronised bus line levels and bus events, from sampler to core.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic bus_busy;
	modport sampler(output scl, sda, scl_rise, scl_fall, start_seen, stop_seen, bus_busy);
	modport core(input scl, sda, scl_rise, scl_fall, start_seen, stop_seen, bus_busy);
endinterface
`default_nettype wire

// >>> core/line_sampler.sv
// Two-flop synchroniser for SCL and SDA plus edge, START and STOP detection.
// Assumes the bus lines are asynchronous to CLOCK.
`timescale 1ns/100ps
`default_nettype none
module line_sampler (
	input wire logic clock,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	line_if.sampler lines
);
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic [1:0] prev_reg;
	logic busy_reg;

	// ****************************************************************
	// Synchroniser, bit 1 is SCL and bit 0 is SDA
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= 2'h3;
			sync2_reg <= 2'h3;
			prev_reg <= 2'h3;
		end else begin
			sync1_reg <= {scl_in, sda_in};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign lines.scl = sync2_reg[1];
	assign lines.sda = sync2_reg[0];
	assign lines.scl_rise = sync2_reg[1] && !prev_reg[1];
	assign lines.scl_fall = !sync2_reg[1] && prev_reg[1];
	assign lines.start_seen = sync2_reg[1] && prev_reg[1] && prev_reg[0] && !sync2_reg[0];
	assign lines.stop_seen = sync2_reg[1] && prev_reg[1] && !prev_reg[0] && sync2_reg[0];
	assign lines.bus_busy = busy_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
		end else if (lines.start_seen) begin
			busy_reg <= 1'b1;
		end else if (lines.stop_seen) begin
			busy_reg <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> core/byte_shifter.sv
// Byte shift register with bit counter: shifts in on sample, out on shift.
// Assumes sample and shift are never high in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module byte_shifter #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clear,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	input wire logic sample,
	input wire logic shift,
	input wire logic bit_in,
	output logic [WIDTH-1:0] data,
	output logic [3:0] count
);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data <= '1;
			count <= 4'h0;
		end else if (clear) begin
			data <= '1;
			count <= 4'h0;
		end else if (load) begin
			data <= load_data;
			count <= 4'h0;
		end else if (sample) begin
			data <= {data[WIDTH-2:0], bit_in};
			count <= count + 4'h1;
		end else if (shift) begin
			data <= {data[WIDTH-2:0], 1'b1};
			count <= count + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/bus_master_model.sv
// Behavioural bus master for the two-wire slave: START, STOP, byte out, byte in.
// Assumes pull-ups: the bench folds every party's drive into the wire levels.
`timescale 1ns/100ps
`default_nettype none
module bus_master_model #(
	parameter real Q = 31.25
) (
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_drv,
	output logic sda_drv
);
	// ****************************************************************
	// Line drivers in quarter steps of a 125 ns SCL period
	// ****************************************************************
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic pulse(output logic s);
		int n;
		#Q scl_drv = 1'b1;
		n = 0;
		// The slave may stretch the low phase
		while (scl_w !== 1'b1 && n < 20000) begin
			#1 n++;
		end
		#Q s = sda_w;
		#Q scl_drv = 1'b0;
		#Q;
	endtask
	task automatic start_cond();
		sda_drv = 1'b0;
		#(2*Q) scl_drv = 1'b0;
		#Q;
	endtask
	task automatic stop_cond();
		sda_drv = 1'b0;
		#Q scl_drv = 1'b1;
		#Q sda_drv = 1'b1;
		#(2*Q);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_drv = b[i];
			pulse(s);
		end
		sda_drv = 1'b1;
		pulse(s);
		ack = ~s;
	endtask
	task automatic recv(input logic ack_it, output logic [7:0] b);
		logic s;
		sda_drv = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			pulse(s);
			b[i] = s;
		end
		// SDA takes the ack level now, with SCL low, and stays there until the next call moves it
		sda_drv = ~ack_it;
		pulse(s);
	endtask
endmodule
`default_nettype wire

// >>> tb/two_wire_slave_receiver_tb.sv
// Self-checking bench of the two-wire slave receiver.
// Assumes the bus master model and pull-ups on SCL and SDA.
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_receiver_tb;
	logic CLOCK, RSTN, REG_WR, REG_RD, ARB_LOST, SLEEP_DEEP, SCL_OE, SDA_OE;
	logic WAKE, START_HELD, m_scl, m_sda, ack, SCL_OUT, SDA_OUT;
	logic [1:0] REG_ADDR;
	logic [7:0] REG_WDATA, REG_RDATA, d;
	int failures, n_checks;
	wire scl_w = m_scl & (!SCL_OE | SCL_OUT);
	wire sda_w = m_sda & (!SDA_OE | SDA_OUT);

	two_wire_slave_receiver dut (.CLOCK(CLOCK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.SCL_IN(scl_w), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda_w),
		.SDA_OUT(SDA_OUT),
		.SDA_OE(SDA_OE), .ARB_LOST(ARB_LOST), .SLEEP_DEEP(SLEEP_DEEP), .WAKE(WAKE),
		.START_HELD(START_HELD));
	bus_master_model bm (.scl_w(scl_w), .sda_w(sda_w), .scl_drv(m_scl), .sda_drv(m_sda));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge CLOCK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= v;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge CLOCK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1 v = REG_RDATA;
	endtask
	task automatic stat_is(input logic [7:0] want);
		logic [7:0] v;
		rd(tw_pkg::STATUS_IDX, v);
		check(v & 8'hF8, want);
	endtask
	task automatic rst();
		RSTN <= 1'b0;
		repeat (8) @(posedge CLOCK);
		RSTN <= 1'b1;
		@(posedge CLOCK);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_own_rx();
		rst();
		rd(tw_pkg::OWN_ADDR_IDX, d);
		check(d, 8'h00);
		stat_is(8'hF8);
		check(SDA_OE, 1'b0);
		wr(tw_pkg::OWN_ADDR_IDX, 8'hA4);
		rd(tw_pkg::OWN_ADDR_IDX, d);
		check(d, 8'hA4);
		wr(tw_pkg::CTRL_IDX, 8'h44);
		bm.start_cond();
		bm.send(8'hA4, ack);
		check(ack, 1'b1);
		rd(tw_pkg::CTRL_IDX, d);
		check(d[7], 1'b1);
		stat_is(tw_pkg::ST_OWN_W);
		check(SCL_OE, 1'b1);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		bm.send(8'h3C, ack);
		check(ack, 1'b1);
		stat_is(tw_pkg::ST_RX_ACK_OWN);
		rd(tw_pkg::DATA_IDX, d);
		check(d, 8'h3C);
		wr(tw_pkg::CTRL_IDX, 8'h84);
		bm.send(8'h5A, ack);
		check(ack, 1'b0);
		stat_is(tw_pkg::ST_RX_NACK_OWN);
		wr(tw_pkg::CTRL_IDX, 8'hE4);
		bm.stop_cond();
		repeat (400) @(posedge CLOCK);
		check(START_HELD, 1'b0);
		check(SDA_OE, 1'b1);
		repeat (420) @(posedge CLOCK);
		check(START_HELD, 1'b1);
		check(SCL_OE, 1'b1);
	endtask
	task automatic t_gc_sleep();
		rst();
		SLEEP_DEEP <= 1'b1;
		wr(tw_pkg::OWN_ADDR_IDX, 8'hA4);
		wr(tw_pkg::CTRL_IDX, 8'h44);
		bm.start_cond();
		bm.send(8'h00, ack);
		check(ack, 1'b0);
		check(WAKE, 1'b0);
		bm.stop_cond();
		wr(tw_pkg::OWN_ADDR_IDX, 8'hA5);
		bm.start_cond();
		bm.send(8'h00, ack);
		check(ack, 1'b1);
		check(WAKE, 1'b1);
		stat_is(tw_pkg::ST_GC_W);
		check(SCL_OE, 1'b1);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		repeat (4) @(posedge CLOCK);
		check(SCL_OE, 1'b0);
		bm.send(8'h11, ack);
		check(ack, 1'b1);
		stat_is(tw_pkg::ST_RX_ACK_GC);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		SLEEP_DEEP <= 1'b0;
		bm.stop_cond();
	endtask
	task automatic t_arb();
		rst();
		wr(tw_pkg::OWN_ADDR_IDX, 8'hA4);
		wr(tw_pkg::CTRL_IDX, 8'h04);
		bm.start_cond();
		bm.send(8'hA4, ack);
		check(ack, 1'b0);
		bm.stop_cond();
		wr(tw_pkg::CTRL_IDX, 8'h44);
		@(posedge CLOCK);
		ARB_LOST <= 1'b1;
		@(posedge CLOCK);
		ARB_LOST <= 1'b0;
		bm.start_cond();
		bm.send(8'hA4, ack);
		check(ack, 1'b1);
		stat_is(tw_pkg::ST_ARB_OWN_W);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		bm.stop_cond();
		wr(tw_pkg::OWN_ADDR_IDX, 8'hA5);
		ARB_LOST <= 1'b1;
		@(posedge CLOCK);
		ARB_LOST <= 1'b0;
		bm.start_cond();
		bm.send(8'h00, ack);
		check(ack, 1'b1);
		stat_is(tw_pkg::ST_ARB_GC_W);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		bm.stop_cond();
	endtask
	task automatic t_tx_last();
		rst();
		wr(tw_pkg::OWN_ADDR_IDX, 8'hA4);
		wr(tw_pkg::CTRL_IDX, 8'h44);
		bm.start_cond();
		bm.send(8'hA5, ack);
		check(ack, 1'b1);
		stat_is(tw_pkg::ST_OWN_R);
		wr(tw_pkg::DATA_IDX, 8'h96);
		wr(tw_pkg::CTRL_IDX, 8'h84);
		bm.recv(1'b1, d);
		check(d, 8'h96);
		stat_is(tw_pkg::ST_TX_LAST_ACK);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		bm.recv(1'b0, d);
		check(d, 8'hFF);
		bm.stop_cond();
		bm.start_cond();
		bm.send(8'hA4, ack);
		check(ack, 1'b1);
		wr(tw_pkg::CTRL_IDX, 8'hC4);
		bm.stop_cond();
	endtask

	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	initial begin
		RSTN = 1'b0;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 2'h0;
		REG_WDATA = 8'h00;
		ARB_LOST = 1'b0;
		SLEEP_DEEP = 1'b0;
		t_own_rx();
		t_gc_sleep();
		t_arb();
		t_tx_last();
		wrap_up();
	end
endmodule
`default_nettype wire
